// >>> src/mul_quot_shift_unit.sv
/*
 Multiplier/quotient shift unit: MQ load, circular and logical left
 shifts, divide/BCD load and registered status flags.
 Assumes a microcode controller on mclk_i supplying instruction and
 operands; pin inputs are synchronised here.
*/
`timescale 1ns/10ps
`default_nettype none
module mul_quot_shift_unit
    import mqsu_pkg::*;
(
    // Clock and reset
    input wire logic mclk_i,
    input wire logic reset_n_i,
    // Instruction and operands
    input wire logic [INSTR_W-1:0] instr_i,
    input wire logic [DATA_W-1:0] r_operand_i,
    input wire logic [DATA_W-1:0] second_data_bus_i,
    input wire logic carry_input_i,
    input wire logic [1:0] word_cfg_i,
    // Pins
    input wire logic shift_condition_pin_i,
    input wire logic serial_end_fill_low_n_i,
    input wire logic serial_end_fill_1_n_i,
    input wire logic serial_end_fill_2_n_i,
    input wire logic serial_end_fill_high_n_i,
    // Results
    output logic [DATA_W-1:0] y_o,
    output logic y_valid_o,
    output logic [DATA_W-1:0] mul_quot_reg_o,
    output logic [DATA_W-1:0] div_bcd_o,
    // Status
    output logic zero_o,
    output logic msb_o,
    output logic overflow_flag_o,
    output logic carry_o
);
    // ==========================================================
    // Reset release
    logic [1:0] rst_sync_q;
    logic rst_n;
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rst_sync_q <= 2'b00;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    // ==========================================================
    // Pin synchronisers, two stages each
    logic [4:0] pin_s1_q;
    logic [4:0] pin_s2_q;
    logic [4:0] pin_raw;
    assign pin_raw = {shift_condition_pin_i, serial_end_fill_high_n_i,
                      serial_end_fill_2_n_i, serial_end_fill_1_n_i,
                      serial_end_fill_low_n_i};
    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            pin_s1_q <= 5'h1f;
            pin_s2_q <= 5'h1f;
        end else begin
            pin_s1_q <= pin_raw;
            pin_s2_q <= pin_s1_q;
        end
    end

    // ==========================================================
    // ALU core
    alu_slice_if alu_bus ();
    alu_core u_alu (
        .a(alu_bus.core)
    );
    logic [3:0] shift_sel;
    assign shift_sel = instr_i[SHIFT_OP_LSB +: 4];
    assign alu_bus.op = instr_i[ALU_OP_LSB +: 4];
    assign alu_bus.r_val = r_operand_i;
    assign alu_bus.s_val = second_data_bus_i;
    assign alu_bus.carry_in = carry_input_i;

    // ==========================================================
    // Instruction decode
    word_cfg_t cfg;
    logic is_divbcd;
    logic is_mq_group;
    logic is_shift;
    logic shift_ok;
    always_comb begin
        cfg = word_cfg_t'(word_cfg_i);
        // The divide/BCD code has a zero upper nibble, so the two
        // decodes never overlap
        is_divbcd = (instr_i == OP_LOAD_DIVBCD);
        is_mq_group = shift_sel inside {SH_LOAD_MQ, SH_MQ_CIRC_LEFT,
                                        SH_MQ_LOGIC_LEFT};
        is_shift = is_mq_group && (shift_sel != SH_LOAD_MQ);
        // A released condition pin reads high through the synchroniser
        shift_ok = pin_s2_q[4];
    end

    // ==========================================================
    // End-fill selection
    // Full-word mode listens to the bottom pin only; code 10 counts as
    // a full word here just as it does in the shifter
    logic [3:0] fill_n;
    always_comb begin
        fill_n = pin_s2_q[3:0];
        if (!(cfg inside {CFG_W8, CFG_W16})) begin
            fill_n[3:1] = 3'b111;
        end
    end

    // ==========================================================
    // Result port: unshifted ALU result and its one-cycle strobe
    logic [DATA_W-1:0] y_d;
    logic [DATA_W-1:0] y_q;
    logic y_valid_d;
    logic y_valid_q;
    always_comb begin
        y_d = y_q;
        y_valid_d = 1'b0;
        if (is_mq_group) begin
            // Delivered whatever the shift condition says
            y_d = alu_bus.result;
            y_valid_d = 1'b1;
        end
    end

    // Register the result port
    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            y_q <= '0;
            y_valid_q <= 1'b0;
        end else begin
            y_q <= y_d;
            y_valid_q <= y_valid_d;
        end
    end

    // ==========================================================
    // Multiplier/quotient register
    logic [DATA_W-1:0] mq_d;
    logic [DATA_W-1:0] mq_q;
    logic [DATA_W-1:0] shifted;
    always_comb begin
        // Each shift reads the register as it stood before this edge
        shifted = mq_left(mq_q, cfg, shift_sel == SH_MQ_CIRC_LEFT,
                          fill_n);
        mq_d = mq_q;
        if (is_mq_group && shift_sel == SH_LOAD_MQ) begin
            mq_d = alu_bus.result;
        end else if (is_shift && shift_ok) begin
            mq_d = shifted;
        end
    end

    // Register the multiplier/quotient word
    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            mq_q <= MQ_RESET;
        end else begin
            mq_q <= mq_d;
        end
    end

    // ==========================================================
    // Divide/BCD flip-flops
    logic [DATA_W-1:0] dbcd_d;
    logic [DATA_W-1:0] dbcd_q;
    always_comb begin
        dbcd_d = dbcd_q;
        if (is_divbcd) begin
            // Straight from the bus, past the ALU and the MQ shifter
            dbcd_d = second_data_bus_i;
        end
    end

    // Register the divide/BCD word
    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            dbcd_q <= DIVBCD_RESET;
        end else begin
            dbcd_q <= dbcd_d;
        end
    end

    // ==========================================================
    // Status flags
    logic zero_d;
    logic zero_q;
    logic msb_d;
    logic msb_q;
    logic ovr_d;
    logic ovr_q;
    logic carry_d;
    logic carry_q;
    always_comb begin
        zero_d = zero_q;
        msb_d = msb_q;
        ovr_d = ovr_q;
        carry_d = carry_q;
        if (is_divbcd) begin
            // Divide/BCD load reports a clean status
            zero_d = 1'b0;
            msb_d = 1'b0;
            ovr_d = 1'b0;
            carry_d = 1'b0;
        end else if (is_mq_group) begin
            // No shifter sits on the result path in these operations,
            // so the unshifted result is also the post-shift value
            carry_d = alu_bus.carry_out;
            ovr_d = alu_bus.overflow;
            zero_d = (alu_bus.result == '0);
            msb_d = alu_bus.result[DATA_W-1];
        end
    end

    // Register the status flags
    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            zero_q <= 1'b0;
            msb_q <= 1'b0;
            ovr_q <= 1'b0;
            carry_q <= 1'b0;
        end else begin
            zero_q <= zero_d;
            msb_q <= msb_d;
            ovr_q <= ovr_d;
            carry_q <= carry_d;
        end
    end

    // Outputs straight from flip-flops
    assign y_o = y_q;
    assign y_valid_o = y_valid_q;
    assign mul_quot_reg_o = mq_q;
    assign div_bcd_o = dbcd_q;
    assign zero_o = zero_q;
    assign msb_o = msb_q;
    assign overflow_flag_o = ovr_q;
    assign carry_o = carry_q;
endmodule
`default_nettype wire

// >>> src/mqsu_pkg.sv
/*
 Package for the multiplier/quotient shift unit: opcode fields,
 configuration codes, reset values and the shared word-shift functions.
 Assumes a 32-bit datapath cut into four byte slices.
*/
package mqsu_pkg;
    // ==========================================================
    // Widths and fields
    localparam int DATA_W = 32;
    localparam int INSTR_W = 8;
    localparam int ALU_OP_LSB = 0;
    localparam int SHIFT_OP_LSB = 4;
    localparam logic [DATA_W-1:0] MQ_RESET = 32'h0000_0000;
    localparam logic [DATA_W-1:0] DIVBCD_RESET = 32'h0000_0000;

    // ==========================================================
    // Instruction codes (full byte, bits 17-10)
    localparam logic [7:0] OP_LOAD_DIVBCD = 8'h0f;
    // Upper nibble shift selections
    localparam logic [3:0] SH_LOAD_MQ = 4'hf;
    localparam logic [3:0] SH_MQ_CIRC_LEFT = 4'hd;
    localparam logic [3:0] SH_MQ_LOGIC_LEFT = 4'hc;

    // Lower nibble ALU operations
    typedef enum logic [3:0] {
        ALU_ADD = 4'h1,
        ALU_SUB_RS = 4'h2,
        ALU_SUB_SR = 4'h3,
        ALU_INC_S_NOT = 4'h5,
        ALU_INC_R = 4'h6,
        ALU_INC_S = 4'h4,
        ALU_AND = 4'h8,
        ALU_OR = 4'h9,
        ALU_XOR = 4'ha
    } alu_op_t;

    // Word configuration: byte, halfword or full word
    typedef enum logic [1:0] {
        CFG_W8 = 2'b00,
        CFG_W16 = 2'b01,
        CFG_W32 = 2'b11
    } word_cfg_t;

    // Slice k is the top byte of its word
    function automatic logic word_top(input word_cfg_t cfg,
                                      input int k);
        unique case (cfg)
            CFG_W8: word_top = 1'b1;
            CFG_W16: word_top = (k % 2) == 1;
            default: word_top = (k == 3);
        endcase
    endfunction

    // Slice k is the bottom byte of its word
    function automatic logic word_bot(input word_cfg_t cfg,
                                      input int k);
        unique case (cfg)
            CFG_W8: word_bot = 1'b1;
            CFG_W16: word_bot = (k % 2) == 0;
            default: word_bot = (k == 0);
        endcase
    endfunction

    // One-bit left shift per word; rotate or fill from end-fill pins
    function automatic logic [31:0] mq_left(input logic [31:0] v,
            input word_cfg_t cfg, input logic circ,
            input logic [3:0] fill_n);
        logic [31:0] r;
        int top;
        r = '0;
        top = 0;
        for (int k = 0; k < 4; k++) begin
            r[8*k+1 +: 7] = v[8*k +: 7];
            if (!word_bot(cfg, k)) begin
                r[8*k] = v[8*k-1];
            end else begin
                top = (cfg == CFG_W8) ? k : (cfg == CFG_W16) ? k + 1 : 3;
                // Circular feeds word MSB, logical fills 0 or 1 on the pin of the word's bottom slice
                r[8*k] = circ ? v[8*top+7] : ~fill_n[k];
            end
        end
        mq_left = r;
    endfunction
endpackage

// >>> src/alu_slice_if.sv
/*
 Interface between the shift unit and its ALU core.
 Assumes a single clock domain; purely combinational signals.
*/
`timescale 1ns/10ps
`default_nettype none
interface alu_slice_if;
    import mqsu_pkg::*;
    logic [3:0] op;
    logic [DATA_W-1:0] r_val;
    logic [DATA_W-1:0] s_val;
    logic carry_in;
    logic [DATA_W-1:0] result;
    logic carry_out;
    logic overflow;
    modport core (input op, r_val, s_val, carry_in,
                  output result, carry_out, overflow);
    modport user (output op, r_val, s_val, carry_in,
                  input result, carry_out, overflow);
endinterface
`default_nettype wire

// >>> src/alu_core.sv
/*
 Combinational ALU core for the lower instruction nibble.
 Assumes operands and carry are stable in the calling cycle.
*/
`timescale 1ns/10ps
`default_nettype none
module alu_core
    import mqsu_pkg::*;
(
    alu_slice_if.core a
);
    // ==========================================================
    // Operation select with carry and signed overflow
    logic [DATA_W:0] sum;
    logic [DATA_W-1:0] x;
    logic [DATA_W-1:0] y;
    always_comb begin
        x = a.r_val;
        y = a.s_val;
        unique case (alu_op_t'(a.op))
            ALU_SUB_RS: y = ~a.s_val;
            ALU_SUB_SR: x = ~a.r_val;
            ALU_INC_R: y = '0;
            ALU_INC_S: x = '0;
            ALU_INC_S_NOT: begin
                x = '0;
                y = ~a.s_val;
            end
            default: ;
        endcase
        sum = {1'b0, x} + {1'b0, y} + {{DATA_W{1'b0}}, a.carry_in};
        a.result = sum[DATA_W-1:0];
        a.carry_out = sum[DATA_W];
        a.overflow = (x[DATA_W-1] == y[DATA_W-1])
            && (sum[DATA_W-1] != x[DATA_W-1]);
        unique case (alu_op_t'(a.op))
            ALU_AND: a.result = a.r_val & a.s_val;
            ALU_OR: a.result = a.r_val | a.s_val;
            ALU_XOR: a.result = a.r_val ^ a.s_val;
            default: ;
        endcase
        if (a.op inside {ALU_AND, ALU_OR, ALU_XOR}) begin
            a.carry_out = 1'b0;
            a.overflow = 1'b0;
        end
    end
endmodule
`default_nettype wire

// >>> tb/mqsu_props.sv
/*
 Checker for the shift unit, bound to its top module.
 Assumes pins are held for several cycles around each instruction.
*/
`timescale 1ns/10ps
`default_nettype none
module mqsu_props
    import mqsu_pkg::*;
(
    // Clock and reset
    input wire logic mclk_i,
    input wire logic reset_n_i,
    // Instruction, operands and pins
    input wire logic [INSTR_W-1:0] instr_i,
    input wire logic [DATA_W-1:0] r_operand_i,
    input wire logic [DATA_W-1:0] second_data_bus_i,
    input wire logic carry_input_i,
    input wire logic [1:0] word_cfg_i,
    input wire logic shift_condition_pin_i,
    input wire logic serial_end_fill_low_n_i,
    // Results and status
    input wire logic [DATA_W-1:0] y_o,
    input wire logic y_valid_o,
    input wire logic [DATA_W-1:0] mul_quot_reg_o,
    input wire logic [DATA_W-1:0] div_bcd_o,
    input wire logic zero_o,
    input wire logic msb_o,
    input wire logic overflow_flag_o,
    input wire logic carry_o
);
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!reset_n_i);
    // ==========================================================
    // Shift selection and the add reference
    logic [3:0] sh;
    logic [DATA_W:0] sum;
    logic add;
    assign sh = instr_i[7:4];
    assign add = (sh[3:2] == 2'b11) && sh != 4'he && instr_i[3:0] == 4'h1;
    assign sum = {1'b0, r_operand_i} + {1'b0, second_data_bus_i}
        + {32'h0, carry_input_i};
    // ==========================================================
    // Properties
    a_bcd_load: assert property (
        instr_i == OP_LOAD_DIVBCD |=> div_bcd_o == $past(second_data_bus_i))
        else $error("divide load mismatch");
    a_bcd_quiet: assert property (
        instr_i == OP_LOAD_DIVBCD |=> !y_valid_o && $stable(y_o)
        && $stable(mul_quot_reg_o) && !zero_o && !msb_o
        && !overflow_flag_o && !carry_o) else $error("divide load side effect");
    a_load_mq: assert property (
        sh == SH_LOAD_MQ |=> y_valid_o && mul_quot_reg_o == y_o)
        else $error("mq load mismatch");
    a_add_sum: assert property (
        add |=> y_o == $past(sum[31:0]) && carry_o == $past(sum[32]))
        else $error("add result mismatch");
    a_add_ovr: assert property (
        add |=> overflow_flag_o == $past(r_operand_i[31] ==
        second_data_bus_i[31] && sum[31] != r_operand_i[31]))
        else $error("overflow mismatch");
    a_zero_msb: assert property (
        y_valid_o |-> zero_o == (y_o == 32'h0) && msb_o == y_o[31])
        else $error("zero or msb flag mismatch");
    a_circ_word: assert property (
        shift_condition_pin_i [*4] ##0 sh == SH_MQ_CIRC_LEFT &&
        word_cfg_i == CFG_W32 |=> mul_quot_reg_o ==
        {$past(mul_quot_reg_o[30:0]), $past(mul_quot_reg_o[31])})
        else $error("circular shift mismatch");
    a_logic_word: assert property (
        (shift_condition_pin_i && $stable(serial_end_fill_low_n_i)) [*4]
        ##0 sh == SH_MQ_LOGIC_LEFT && word_cfg_i == CFG_W32 |=>
        mul_quot_reg_o == {$past(mul_quot_reg_o[30:0]),
        ~$past(serial_end_fill_low_n_i)}) else $error("left shift mismatch");
    a_inhibit: assert property (
        !shift_condition_pin_i [*4] ##0 sh[3:1] == 3'b110 |=>
        $stable(mul_quot_reg_o) && y_valid_o)
        else $error("inhibited shift mismatch");
endmodule
bind mul_quot_shift_unit mqsu_props i_props (.mclk_i, .reset_n_i,
    .instr_i, .r_operand_i, .second_data_bus_i, .carry_input_i,
    .word_cfg_i, .shift_condition_pin_i, .serial_end_fill_low_n_i,
    .y_o, .y_valid_o, .mul_quot_reg_o, .div_bcd_o, .zero_o, .msb_o,
    .overflow_flag_o, .carry_o);
`default_nettype wire

// >>> tb/ctrl_model.sv
/*
 Microcode controller model: drives instruction and operand fields.
 Assumes the unit takes each instruction at the next rising edge.
*/
`timescale 1ns/10ps
`default_nettype none
module ctrl_model
    import mqsu_pkg::*;
(
    // Clock
    input wire logic clk_i,
    // Instruction and operands
    output logic [INSTR_W-1:0] instr_o,
    output logic [DATA_W-1:0] r_o,
    output logic [DATA_W-1:0] s_o,
    output logic cn_o
);
    // ==========================================================
    // Idle code at time zero
    initial begin
        instr_o = 8'h00;
        r_o = 32'h0;
        s_o = 32'h0;
        cn_o = 1'b0;
    end
    // One microinstruction; R and S operands scrambled once released, carry held
    task automatic issue(input logic [3:0] sh, input logic [3:0] op,
            input logic [31:0] r, input logic [31:0] s, input logic cn);
        @(posedge clk_i);
        instr_o <= {sh, op};
        r_o <= r;
        s_o <= s;
        cn_o <= cn;
        @(posedge clk_i);
        instr_o <= 8'h00;
        r_o <= ~r;
        s_o <= ~s;
        #1;
    endtask
endmodule
`default_nettype wire

// >>> tb/tb_multiplier_quotient_shift_unit.sv
/*
 Testbench for the shift unit: the controller model issues words,
 the bench drives pins and word size. Assumes a 4 ns clock.
*/
`timescale 1ns/10ps
`default_nettype none
module tb_multiplier_quotient_shift_unit;
    import mqsu_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic cond = 1'b1;
    logic [3:0] fill_n = 4'hf;
    logic [1:0] cfg = CFG_W32;
    logic [7:0] instr;
    logic [31:0] r, s, y, mq, dbcd;
    logic cn, yv, zf, nf, vf, cf;
    int fails = 0;
    int tests_run = 0;
    word_cfg_t cfgs[3] = '{CFG_W8, CFG_W16, CFG_W32};
    // ==========================================================
    // Clock, controller and unit
    always #2 clk = ~clk;
    ctrl_model i_ctrl (.clk_i(clk), .instr_o(instr), .r_o(r), .s_o(s),
        .cn_o(cn));
    mul_quot_shift_unit i_dut (.mclk_i(clk), .reset_n_i(rst_n),
        .instr_i(instr), .r_operand_i(r), .second_data_bus_i(s),
        .carry_input_i(cn), .word_cfg_i(cfg), .shift_condition_pin_i(cond),
        .serial_end_fill_low_n_i(fill_n[0]), .serial_end_fill_1_n_i(fill_n[1]),
        .serial_end_fill_2_n_i(fill_n[2]),
        .serial_end_fill_high_n_i(fill_n[3]), .y_o(y), .y_valid_o(yv),
        .mul_quot_reg_o(mq), .div_bcd_o(dbcd), .zero_o(zf), .msb_o(nf),
        .overflow_flag_o(vf), .carry_o(cf));
    // ==========================================================
    // Compares, reference shift and closing report
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chkf(input logic [4:0] exp);
        chk({27'h0, yv, zf, nf, vf, cf}, {27'h0, exp});
    endtask
    function automatic logic [31:0] shl(input logic [31:0] v, input int w,
            input logic circ, input logic [3:0] f);
        for (int i = 0; i < 32; i++) begin
            shl[i] = (i % w) ? v[i-1] : (circ ? v[i+w-1] : ~f[i/8]);
        end
    endfunction
    // Pins pass two flops, so let them settle
    task automatic setp(input logic c, input logic [3:0] f,
            input logic [1:0] w);
        @(posedge clk);
        cond <= c;
        fill_n <= f;
        cfg <= w;
        repeat (3) @(posedge clk);
    endtask
    task automatic end_sim;
        $display("Comparisons %0d, mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // Hang guard
    initial begin
        repeat (20000) @(posedge clk);
        fails++;
        end_sim();
    end
    // ==========================================================
    // Main sequence
    initial begin
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        chk(mq, MQ_RESET);
        chk(dbcd, DIVBCD_RESET);
        i_ctrl.issue(SH_LOAD_MQ, ALU_INC_R, 32'h2a08c618, 32'h0, 1'b0);
        chk(mq, 32'h2a08c618);
        chk(y, 32'h2a08c618);
        i_ctrl.issue(SH_LOAD_MQ, ALU_INC_R, 32'h4da99a0e, 32'h0, 1'b0);
        i_ctrl.issue(SH_MQ_CIRC_LEFT, ALU_ADD, 32'h2508c618, 32'h11007530,
            1'b1);
        chk(y, 32'h36093b49);
        chk(mq, 32'h9b53341c);
        chkf(5'b10000);
        i_ctrl.issue(SH_LOAD_MQ, ALU_ADD, 32'h7fffffff, 32'h0, 1'b1);
        chkf(5'b10110);
        i_ctrl.issue(SH_LOAD_MQ, ALU_ADD, 32'hffffffff, 32'h1, 1'b0);
        chkf(5'b11001);
        for (int k = 0; k < 12; k++) begin
            // Each mode's logical shift sees both fill patterns
            setp(1'b1, k[1] ? 4'b0101 : 4'b1010, cfgs[k%3]);
            i_ctrl.issue(SH_LOAD_MQ, ALU_INC_R, 32'h81c37e01, 32'h0, 1'b0);
            i_ctrl.issue(k[0] ? SH_MQ_CIRC_LEFT : SH_MQ_LOGIC_LEFT, ALU_INC_S,
                32'h0, 32'h5, 1'b1);
            chk(y, 32'h6);
            chk(mq, shl(32'h81c37e01, 8 << (k % 3), k[0],
                fill_n));
        end
        setp(1'b0, 4'hf, CFG_W32);
        i_ctrl.issue(SH_LOAD_MQ, ALU_INC_R, 32'h12345678, 32'h0, 1'b0);
        i_ctrl.issue(SH_MQ_CIRC_LEFT, ALU_OR, 32'hf0, 32'h0f, 1'b0);
        chk(mq, 32'h12345678);
        chk(y, 32'hff);
        i_ctrl.issue(SH_MQ_LOGIC_LEFT, ALU_XOR, 32'hff, 32'h0f, 1'b0);
        chk(mq, 32'h12345678);
        chk(y, 32'hf0);
        i_ctrl.issue(4'h0, 4'hf, 32'h0, 32'h2a08c618, 1'b0);
        chk(dbcd, 32'h2a08c618);
        chk(y, 32'hf0);
        chk(mq, 32'h12345678);
        chkf(5'b00000);
        end_sim();
    end
endmodule
`default_nettype wire
